// File: include/ostr_pkg.sv
package ostr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] TRIM_OFFSET = 4'h0;
  localparam int TRIM_CODE_W = 5;
  localparam int TRIM_CODE_LSB = 0;
  localparam int RSVD_BIT = 5;
  localparam int PLL_EN_BIT = 6;
  localparam int SRC_SEL_BIT = 7;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [4:0] TRIM_CENTER = 5'h00;
  localparam logic [4:0] TRIM_MIN = 5'h10;
  localparam logic [4:0] TRIM_MAX = 5'h0F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Offset-binary step index: flip sign bit, 0 = slowest, 31 = fastest
  localparam logic [4:0] STEP_SIGN_FLIP = 5'h10;
endpackage

// File: logic/ostr_trim.sv
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ostr_trim (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pll_supported, // Oscillator mode allows PLL (same domain)
  input wire logic [ostr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ostr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [4:0] main_osc_step, // Main oscillator step index
  output logic low_freq_source_select, // 31 kHz source select
  output logic pll_multiplier_enable, // 4x multiplier on
  output logic [4:0] low_power_rc_trim // Low-power RC trim, fixed
);
  import ostr_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [4:0] trim_code;
    logic pll_bit;
    logic src_sel;
    logic [4:0] step;
    logic pll_on;
  } ostr_state_t;

  ostr_state_t state_reg;
  ostr_state_t state_next;
  logic do_write;
  logic [7:0] trim_view;

  // Stored PLL bit only shows where the PLL exists
  always_comb begin
    trim_view = '0;
    trim_view[TRIM_CODE_LSB +: TRIM_CODE_W] = state_reg.trim_code;
    trim_view[PLL_EN_BIT] = state_reg.pll_bit & pll_supported;
    trim_view[RSVD_BIT] = 1'b0;
    trim_view[SRC_SEL_BIT] = state_reg.src_sel;
  end

  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign do_write = state_reg.aw_held && state_reg.w_held
    && !state_reg.bvalid;

  always_comb begin
    state_next = state_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      if (state_reg.aw_addr == TRIM_OFFSET) begin
        state_next.bresp = RESP_OKAY;
        if (state_reg.w_strb[0]) begin
          // Applied at once; no completion flag exists
          state_next.trim_code =
            state_reg.w_data[TRIM_CODE_LSB +: TRIM_CODE_W];
          state_next.pll_bit = state_reg.w_data[PLL_EN_BIT] & pll_supported;
          state_next.src_sel = state_reg.w_data[SRC_SEL_BIT];
        end
      end else begin
        state_next.bresp = RESP_SLVERR;
      end
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      if (s_axi_araddr == TRIM_OFFSET) begin
        state_next.rdata = {24'h000000, trim_view};
        state_next.rresp = RESP_OKAY;
      end else begin
        state_next.rdata = 32'h00000000;
        state_next.rresp = RESP_SLVERR;
      end
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // Signed code to monotonic, evenly spaced step index
    state_next.step = state_next.trim_code ^ STEP_SIGN_FLIP;
    state_next.pll_on = state_next.pll_bit & pll_supported;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.step <= STEP_SIGN_FLIP;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;
  assign main_osc_step = state_reg.step;
  assign low_freq_source_select = state_reg.src_sel;
  assign pll_multiplier_enable = state_reg.pll_on & pll_supported;
  assign low_power_rc_trim = TRIM_CENTER;

  a_step_order: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (state_reg.trim_code == TRIM_MIN) |-> (main_osc_step == 5'h00))
    else $error("minimum trim code not slowest step");
  a_step_center: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    (state_reg.trim_code == TRIM_CENTER) |-> (main_osc_step == 5'h10))
    else $error("centre trim code not centre step");
  a_step_mono: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    ($signed(state_reg.trim_code) > $signed($past(state_reg.trim_code)))
    |-> (main_osc_step > $past(main_osc_step)))
    else $error("raised trim did not raise frequency");
  a_rc_fixed: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    low_power_rc_trim == TRIM_CENTER)
    else $error("low-power oscillator moved");
  a_pll_gated: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rresp[1] && !pll_supported
    && $rose(s_axi_rvalid) |-> !s_axi_rdata[PLL_EN_BIT])
    else $error("pll bit read as one when unsupported");
  a_rsvd_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_rdata[RSVD_BIT])
    else $error("reserved bit read as one");
  a_write_takes: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    do_write && state_reg.aw_addr == TRIM_OFFSET && state_reg.w_strb[0]
    |=> low_freq_source_select == $past(state_reg.w_data[SRC_SEL_BIT])
    ##0 s_axi_bvalid)
    else $error("write to trim register not applied");
  a_pll_follow: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    pll_multiplier_enable |-> state_reg.pll_bit && pll_supported)
    else $error("multiplier on without enable");
endmodule // ostr_trim
`default_nettype wire

// File: test/internal_osc_trim_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module internal_osc_trim_register_test;
  import ostr_pkg::*;
  logic ref_clk, rst_n, pll_supported, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] main_osc_step, low_power_rc_trim;
  logic low_freq_source_select, pll_multiplier_enable;
  logic [31:0] rd, d;
  logic [7:0] m, ev;
  int err_count, total_checks;
  ostr_trim uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .pll_supported(pll_supported),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .main_osc_step(main_osc_step),
    .low_freq_source_select(low_freq_source_select),
    .pll_multiplier_enable(pll_multiplier_enable),
    .low_power_rc_trim(low_power_rc_trim)
  );
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Both channels offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Stored PLL bit is only visible while the PLL is supported
  task outs();
    ev = m & {1'b1, pll_supported, 6'h3F};
    chk("step", {27'h0, m[4:0] ^ 5'h10}, {27'h0, main_osc_step});
    chk("src", {31'h0, m[7]}, {31'h0, low_freq_source_select});
    chk("pll", {31'h0, ev[6]}, {31'h0, pll_multiplier_enable});
    chk("rc", 32'h0, {27'h0, low_power_rc_trim});
    rdr(4'h0);
    chk("rdata", {24'h0, ev}, rd);
  endtask
  task print_verdict();
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    {s_axi_wdata, s_axi_wstrb} = 0;
    pll_supported = 1;
    m = 8'h00;
    void'($urandom(32'hdb81));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    outs();
    for (int i = 0; i < 30; i++) begin
      d = (i < 3) ? {24'h0, 8'h10 + 8'h0F * i[7:0]} : $urandom;
      @(posedge ref_clk);
      pll_supported <= (i > 2) ? $urandom_range(1) : 1'b1;
      @(posedge ref_clk);
      wr(4'h0, d, (i % 7 == 6) ? 4'hE : 4'hF);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
      if (i % 7 != 6) m = d[7:0] & {1'b1, pll_supported, 6'h1F};
      outs();
    end
    wr(4'h4, 32'hFF, 4'hF);
    chk("bresp bad", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rdr(4'h8);
    chk("rresp bad", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("rdata bad", 32'h0, rd);
    outs();
    print_verdict();
  end
endmodule // internal_osc_trim_register_test
`default_nettype wire
